// File: xic_top.sv
// Notes on behaviour
// - low priority bits, cmp0 at bit 7 down to spi at bit 0, read/write.
// - high priority bits, same source order as the low register.
// - enable bit 1 gates the comparator 1 request.
// - enable bit 0 gates the timer 3 request.
// - second priority pair holds cmp1 at bit 1, timer3 at bit 0, reset zero.
// - input 1 select low bits in config 0 [7:6], top bit config 1 [7].
// - input 1 codes pick P3.3 P3.1 P3.5 P4.1 P4.5 P1.5 P3.7 P0.7.
// - input 0 select low bits in config 0 [5:4], top bit config 1 [6].
// - input 0 codes pick P3.2 P3.0 P3.4 P4.0 P1.0 P1.4 P3.6 P0.5.
// - input 2 select low bits in config 1 [5:4], top bit config 2 [0].
// - input 2 codes pick P4.3 P2.0 P1.1 P2.6 P4.4 P6.0 P0.1 P4.6.
// - input 3 select in config 2 [3:1]; upper nibble resets to zero.
// - input 3 codes pick P4.2 P2.1 P0.0 P1.6 P0.2 P6.1 P0.6 P4.7.
// - filter mode n is config 1 bit n over config 0 bit n.
// - modes: off, system clock, clock over six, timer 3 overflow, three samples each except off.
// - config registers share one address, chosen by pages 0, 1 and 2.
// - active low by default, active high when polarity bit set.
module xic_top (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // special-function register access
   input wire logic [7:0] i_sfr_addr,
   input wire logic [3:0] i_sfr_page,
   input wire logic i_sfr_wr,
   input wire logic i_sfr_rd,
   input wire logic [7:0] i_sfr_wdata,
   output logic [7:0] o_sfr_rdata,
   output logic o_sfr_ack,
   // port pins and trigger polarity
   input wire xic_pkg::xic_pins_t i_port_pins,
   input wire logic [3:0] i_xirq_high_polarity,
   // timer 3 overflow tick
   input wire logic i_timer3_overflow_tick,
   // peripheral requests
   input wire logic i_cmp1_irq_req,
   input wire logic i_timer3_irq_req,
   output logic o_cmp1_irq_req,
   output logic o_timer3_irq_req,
   // priority levels
   output xic_pkg::xic_prio_t o_prio_levels,
   // external interrupt inputs after selection and filtering
   output logic [3:0] o_xirq_filtered,
   output logic [3:0] o_xirq_active
);

   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   logic [7:0] prio_1_low_r;
   logic [7:0] prio_1_high_r;
   logic [1:0] prio_2_low_r;
   logic [1:0] prio_2_high_r;
   logic [1:0] irq_enable_2_r;
   logic [7:0] pin_cfg0_r;
   logic [7:0] pin_cfg1_r;
   logic [7:0] pin_cfg2_r;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic ack_r;
   logic cmp1_req_r;
   logic timer3_req_r;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   logic hit_enable_2;
   logic hit_prio_2_low;
   logic hit_prio_2_high;
   logic hit_prio_1_low;
   logic hit_prio_1_high;
   logic hit_cfg0;
   logic hit_cfg1;
   logic hit_cfg2;
   logic hit_any;

   assign hit_enable_2 = (i_sfr_addr == xic_pkg::ADDR_IRQ_ENABLE_2);
   assign hit_prio_2_low = (i_sfr_addr == xic_pkg::ADDR_PRIO_2_LOW);
   assign hit_prio_2_high = (i_sfr_addr == xic_pkg::ADDR_PRIO_2_HIGH);
   assign hit_prio_1_low = (i_sfr_addr == xic_pkg::ADDR_PRIO_1_LOW);
   assign hit_prio_1_high = (i_sfr_addr == xic_pkg::ADDR_PRIO_1_HIGH);
   // one address, page picks the register
   assign hit_cfg0 = (i_sfr_addr == xic_pkg::ADDR_PIN_CFG) &&
                     (i_sfr_page == xic_pkg::PAGE_CFG0);
   assign hit_cfg1 = (i_sfr_addr == xic_pkg::ADDR_PIN_CFG) &&
                     (i_sfr_page == xic_pkg::PAGE_CFG1);
   assign hit_cfg2 = (i_sfr_addr == xic_pkg::ADDR_PIN_CFG) &&
                     (i_sfr_page == xic_pkg::PAGE_CFG2);
   assign hit_any = hit_enable_2 | hit_prio_2_low | hit_prio_2_high |
                    hit_prio_1_low | hit_prio_1_high |
                    hit_cfg0 | hit_cfg1 | hit_cfg2;

   logic wr_enable_2;
   logic wr_prio_2_low;
   logic wr_prio_2_high;
   logic wr_prio_1_low;
   logic wr_prio_1_high;
   logic wr_cfg0;
   logic wr_cfg1;
   logic wr_cfg2;

   assign wr_enable_2 = i_sfr_wr && hit_enable_2;
   assign wr_prio_2_low = i_sfr_wr && hit_prio_2_low;
   assign wr_prio_2_high = i_sfr_wr && hit_prio_2_high;
   assign wr_prio_1_low = i_sfr_wr && hit_prio_1_low;
   assign wr_prio_1_high = i_sfr_wr && hit_prio_1_high;
   assign wr_cfg0 = i_sfr_wr && hit_cfg0;
   assign wr_cfg1 = i_sfr_wr && hit_cfg1;
   assign wr_cfg2 = i_sfr_wr && hit_cfg2;

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   // low and high priority bytes
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         prio_1_low_r <= xic_pkg::RST_PRIO_1;
         prio_1_high_r <= xic_pkg::RST_PRIO_1;
      end else begin
         if (wr_prio_1_low) begin
            prio_1_low_r <= i_sfr_wdata;
         end
         if (wr_prio_1_high) begin
            prio_1_high_r <= i_sfr_wdata;
         end
      end
   end

   // reserved enable bits are not stored, so they read zero
   // second priority pair keeps only two bits
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         irq_enable_2_r <= xic_pkg::RST_ENABLE_2;
         prio_2_low_r <= xic_pkg::RST_PRIO_2;
         prio_2_high_r <= xic_pkg::RST_PRIO_2;
      end else begin
         if (wr_enable_2) begin
            irq_enable_2_r <= i_sfr_wdata[1:0];
         end
         if (wr_prio_2_low) begin
            prio_2_low_r <= i_sfr_wdata[1:0];
         end
         if (wr_prio_2_high) begin
            prio_2_high_r <= i_sfr_wdata[1:0];
         end
      end
   end

   // config 0 and 1 reset to zero
   // config 2 upper nibble is plain storage, given a defined reset
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         pin_cfg0_r <= xic_pkg::RST_CFG0;
         pin_cfg1_r <= xic_pkg::RST_CFG1;
         pin_cfg2_r <= xic_pkg::RST_CFG2;
      end else begin
         if (wr_cfg0) begin
            pin_cfg0_r <= i_sfr_wdata;
         end
         if (wr_cfg1) begin
            pin_cfg1_r <= i_sfr_wdata;
         end
         if (wr_cfg2) begin
            pin_cfg2_r <= i_sfr_wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   // data appears one cycle after the read strobe; unmapped reads give zero
   assign rdata_nxt =
      hit_enable_2 ? {6'h00, irq_enable_2_r} :
      hit_prio_2_low ? {6'h00, prio_2_low_r} :
      hit_prio_2_high ? {6'h00, prio_2_high_r} :
      hit_prio_1_low ? prio_1_low_r :
      hit_prio_1_high ? prio_1_high_r :
      hit_cfg0 ? pin_cfg0_r :
      hit_cfg1 ? pin_cfg1_r :
      hit_cfg2 ? pin_cfg2_r : 8'h00;

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         rdata_r <= 8'h00;
         ack_r <= 1'b0;
      end else begin
         ack_r <= i_sfr_rd && hit_any;
         if (i_sfr_rd) begin
            rdata_r <= rdata_nxt;
         end
      end
   end

   assign o_sfr_rdata = rdata_r;
   assign o_sfr_ack = ack_r;

   // ----------------------------------------------------------------
   // request gating and priority levels
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         cmp1_req_r <= 1'b0;
         timer3_req_r <= 1'b0;
      end else begin
         cmp1_req_r <= i_cmp1_irq_req && irq_enable_2_r[xic_pkg::BIT_CMP1];
         timer3_req_r <= i_timer3_irq_req && irq_enable_2_r[xic_pkg::BIT_TIMER3];
      end
   end

   assign o_cmp1_irq_req = cmp1_req_r;
   assign o_timer3_irq_req = timer3_req_r;

   // level is {high, low}, straight from the registers
   assign o_prio_levels.cmp0 = {prio_1_high_r[xic_pkg::BIT_CMP0],
                                prio_1_low_r[xic_pkg::BIT_CMP0]};
   assign o_prio_levels.twowire0 = {prio_1_high_r[xic_pkg::BIT_TWOWIRE0],
                                    prio_1_low_r[xic_pkg::BIT_TWOWIRE0]};
   assign o_prio_levels.keypad = {prio_1_high_r[xic_pkg::BIT_KEYPAD],
                                  prio_1_low_r[xic_pkg::BIT_KEYPAD]};
   assign o_prio_levels.uart1 = {prio_1_high_r[xic_pkg::BIT_UART1],
                                 prio_1_low_r[xic_pkg::BIT_UART1]};
   assign o_prio_levels.sysflag = {prio_1_high_r[xic_pkg::BIT_SYSFLAG],
                                   prio_1_low_r[xic_pkg::BIT_SYSFLAG]};
   assign o_prio_levels.counter_array = {prio_1_high_r[xic_pkg::BIT_COUNTER_ARRAY],
                                         prio_1_low_r[xic_pkg::BIT_COUNTER_ARRAY]};
   assign o_prio_levels.adc = {prio_1_high_r[xic_pkg::BIT_ADC],
                               prio_1_low_r[xic_pkg::BIT_ADC]};
   assign o_prio_levels.spi = {prio_1_high_r[xic_pkg::BIT_SPI],
                               prio_1_low_r[xic_pkg::BIT_SPI]};
   assign o_prio_levels.cmp1 = {prio_2_high_r[xic_pkg::BIT_CMP1],
                                prio_2_low_r[xic_pkg::BIT_CMP1]};
   assign o_prio_levels.timer3 = {prio_2_high_r[xic_pkg::BIT_TIMER3],
                                  prio_2_low_r[xic_pkg::BIT_TIMER3]};

   // ----------------------------------------------------------------
   // pin synchroniser
   // ----------------------------------------------------------------
   xic_pkg::xic_pins_t pins_meta_r;
   xic_pkg::xic_pins_t pins_sync_r;

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         pins_meta_r <= '1;
         pins_sync_r <= '1;
      end else begin
         pins_meta_r <= i_port_pins;
         pins_sync_r <= pins_meta_r;
      end
   end

   // ----------------------------------------------------------------
   // pin selection
   // ----------------------------------------------------------------
   logic [2:0] sel [4];
   logic [7:0] cand [4];
   logic [3:0] selected;
   logic [3:0] filter_mode;
   logic [3:0] filter_mode_hi;

   assign sel[0] = {pin_cfg1_r[xic_pkg::CFG1_XIRQ0_SEL_HI],
                    pin_cfg0_r[xic_pkg::CFG0_XIRQ0_SEL_LO +: 2]};
   assign sel[1] = {pin_cfg1_r[xic_pkg::CFG1_XIRQ1_SEL_HI],
                    pin_cfg0_r[xic_pkg::CFG0_XIRQ1_SEL_LO +: 2]};
   assign sel[2] = {pin_cfg2_r[xic_pkg::CFG2_XIRQ2_SEL_HI],
                    pin_cfg1_r[xic_pkg::CFG1_XIRQ2_SEL_LO +: 2]};
   assign sel[3] = pin_cfg2_r[xic_pkg::CFG2_XIRQ3_SEL +: 3];

   // candidate vectors, code 7 in the top bit
   // input 0 pin table
   assign cand[0] = {pins_sync_r.p0[5], pins_sync_r.p3[6], pins_sync_r.p1[4],
                     pins_sync_r.p1[0], pins_sync_r.p4[0], pins_sync_r.p3[4],
                     pins_sync_r.p3[0], pins_sync_r.p3[2]};
   assign cand[1] = {pins_sync_r.p0[7], pins_sync_r.p3[7], pins_sync_r.p1[5],
                     pins_sync_r.p4[5], pins_sync_r.p4[1], pins_sync_r.p3[5],
                     pins_sync_r.p3[1], pins_sync_r.p3[3]};
   assign cand[2] = {pins_sync_r.p4[6], pins_sync_r.p0[1], pins_sync_r.p6[0],
                     pins_sync_r.p4[4], pins_sync_r.p2[6], pins_sync_r.p1[1],
                     pins_sync_r.p2[0], pins_sync_r.p4[3]};
   assign cand[3] = {pins_sync_r.p4[7], pins_sync_r.p0[6], pins_sync_r.p6[1],
                     pins_sync_r.p0[2], pins_sync_r.p1[6], pins_sync_r.p0[0],
                     pins_sync_r.p2[1], pins_sync_r.p4[2]};

   assign filter_mode = pin_cfg0_r[xic_pkg::CFG0_FILTER_LO +: 4];
   assign filter_mode_hi = pin_cfg1_r[xic_pkg::CFG1_FILTER_HI +: 4];

   // ----------------------------------------------------------------
   // divide-by-six sample tick
   // ----------------------------------------------------------------
   localparam logic [2:0] DIV_LAST = 3'(xic_pkg::SYSTEM_CLOCK_DIV - 1);
   logic [2:0] div_cnt_r;
   logic tick_div6;

   assign tick_div6 = (div_cnt_r == DIV_LAST);

   // free-running divider so the clock-over-six mode has its tick
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         div_cnt_r <= 3'h0;
      end else if (tick_div6) begin
         div_cnt_r <= 3'h0;
      end else begin
         div_cnt_r <= div_cnt_r + 3'h1;
      end
   end

   // ----------------------------------------------------------------
   // filters and polarity
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_xirq
         xic_pkg::xic_filt_mode_t mode;
         // mode is {config 1 bit n, config 0 bit n}
         assign mode = xic_pkg::xic_filt_mode_t'({filter_mode_hi[gi],
                                                  filter_mode[gi]});
         assign selected[gi] = cand[gi][sel[gi]];

         xic_glitch_filter #(
            .SAMPLES(xic_pkg::FILT_SAMPLES)
         ) u_filter (
            .i_sys_clk(i_sys_clk),
            .i_sys_rst(i_sys_rst),
            .i_din(selected[gi]),
            .i_mode(mode),
            .i_tick_div6(tick_div6),
            .i_tick_t3(i_timer3_overflow_tick),
            .o_dout(o_xirq_filtered[gi])
         );

         // low-active unless the high polarity bit is set
         assign o_xirq_active[gi] = i_xirq_high_polarity[gi] ?
                                    o_xirq_filtered[gi] : ~o_xirq_filtered[gi];
      end
   endgenerate

endmodule : xic_top

// File: xic_pkg.sv
package xic_pkg;

   // ----------------------------------------------------------------
   // special-function addresses and pages
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_IRQ_ENABLE_2 = 8'hA5;
   localparam logic [7:0] ADDR_PRIO_2_LOW = 8'hA6;
   localparam logic [7:0] ADDR_PRIO_2_HIGH = 8'hA7;
   localparam logic [7:0] ADDR_PRIO_1_LOW = 8'hAE;
   localparam logic [7:0] ADDR_PRIO_1_HIGH = 8'hAF;
   localparam logic [7:0] ADDR_PIN_CFG = 8'hC1;
   localparam logic [3:0] PAGE_CFG0 = 4'h0;
   localparam logic [3:0] PAGE_CFG1 = 4'h1;
   localparam logic [3:0] PAGE_CFG2 = 4'h2;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_PRIO_1 = 8'h00;
   localparam logic [1:0] RST_PRIO_2 = 2'h0;
   localparam logic [1:0] RST_ENABLE_2 = 2'h0;
   localparam logic [7:0] RST_CFG0 = 8'h00;
   localparam logic [7:0] RST_CFG1 = 8'h00;
   localparam logic [7:0] RST_CFG2 = 8'h00;
   localparam logic FILT_RESET_LEVEL = 1'b1;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int BIT_CMP1 = 1;
   localparam int BIT_TIMER3 = 0;
   localparam int BIT_CMP0 = 7;
   localparam int BIT_TWOWIRE0 = 6;
   localparam int BIT_KEYPAD = 5;
   localparam int BIT_UART1 = 4;
   localparam int BIT_SYSFLAG = 3;
   localparam int BIT_COUNTER_ARRAY = 2;
   localparam int BIT_ADC = 1;
   localparam int BIT_SPI = 0;
   localparam int CFG0_XIRQ1_SEL_LO = 6;
   localparam int CFG0_XIRQ0_SEL_LO = 4;
   localparam int CFG0_FILTER_LO = 0;
   localparam int CFG1_XIRQ1_SEL_HI = 7;
   localparam int CFG1_XIRQ0_SEL_HI = 6;
   localparam int CFG1_XIRQ2_SEL_LO = 4;
   localparam int CFG1_FILTER_HI = 0;
   localparam int CFG2_XIRQ3_SEL = 1;
   localparam int CFG2_XIRQ2_SEL_HI = 0;

   // ----------------------------------------------------------------
   // timing counts
   // ----------------------------------------------------------------
   localparam int FILT_SAMPLES = 3;
   localparam int SYSTEM_CLOCK_DIV = 6;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      XIC_FILT_OFF = 2'b00,
      XIC_FILT_SYSTEM_CLOCK = 2'b01,
      XIC_FILT_DIV6 = 2'b10,
      XIC_FILT_T3 = 2'b11
   } xic_filt_mode_t;

   typedef struct packed {
      logic [7:0] p6;
      logic [7:0] p4;
      logic [7:0] p3;
      logic [7:0] p2;
      logic [7:0] p1;
      logic [7:0] p0;
   } xic_pins_t;

   typedef struct packed {
      logic [1:0] cmp0;
      logic [1:0] twowire0;
      logic [1:0] keypad;
      logic [1:0] uart1;
      logic [1:0] sysflag;
      logic [1:0] counter_array;
      logic [1:0] adc;
      logic [1:0] spi;
      logic [1:0] cmp1;
      logic [1:0] timer3;
   } xic_prio_t;

endpackage : xic_pkg

// File: xic_glitch_filter.sv
module xic_glitch_filter #(
   parameter int SAMPLES = xic_pkg::FILT_SAMPLES
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // input and mode
   input wire logic i_din,
   input wire xic_pkg::xic_filt_mode_t i_mode,
   // sample ticks
   input wire logic i_tick_div6,
   input wire logic i_tick_t3,
   // filtered level
   output logic o_dout
);

   localparam int CW = $clog2(SAMPLES + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(SAMPLES - 1);
   localparam logic [CW-1:0] CNT_ONE = CW'(1);

   logic out_r;
   logic out_nxt;
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic bypass;
   logic tick;

   assign bypass = (i_mode == xic_pkg::XIC_FILT_OFF);
   assign tick = (i_mode == xic_pkg::XIC_FILT_SYSTEM_CLOCK) ||
                 ((i_mode == xic_pkg::XIC_FILT_DIV6) && i_tick_div6) ||
                 ((i_mode == xic_pkg::XIC_FILT_T3) && i_tick_t3);

   // outside bypass, change only after three equal samples
   always_comb begin
      out_nxt = out_r;
      cnt_nxt = cnt_r;
      if (bypass) begin
         out_nxt = i_din;
         cnt_nxt = '0;
      end else if (tick) begin
         if (i_din == out_r) begin
            cnt_nxt = '0;
         end else if (cnt_r == CNT_LAST) begin
            out_nxt = i_din;
            cnt_nxt = '0;
         end else begin
            cnt_nxt = cnt_r + CNT_ONE;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         out_r <= xic_pkg::FILT_RESET_LEVEL;
         cnt_r <= '0;
      end else begin
         out_r <= out_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign o_dout = out_r;

endmodule : xic_glitch_filter

// File: xic_asserts.sv
module xic_asserts (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // register access
   input wire logic [7:0] i_sfr_addr,
   input wire logic [3:0] i_sfr_page,
   input wire logic i_sfr_wr,
   input wire logic i_sfr_rd,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic [7:0] o_sfr_rdata,
   input wire logic o_sfr_ack,
   // requests, levels and pins
   input wire logic i_cmp1_irq_req,
   input wire logic i_timer3_irq_req,
   input wire logic o_cmp1_irq_req,
   input wire logic o_timer3_irq_req,
   input wire xic_pkg::xic_prio_t o_prio_levels,
   input wire logic [3:0] i_xirq_high_polarity,
   input wire logic [3:0] o_xirq_filtered,
   input wire logic [3:0] o_xirq_active
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] lo_w;
   logic [7:0] hi_w;
   wire mapped_w = (i_sfr_addr inside {8'hA5, 8'hA6, 8'hA7, 8'hAE, 8'hAF}) ||
      (i_sfr_addr == xic_pkg::ADDR_PIN_CFG && i_sfr_page <= xic_pkg::PAGE_CFG2);
   always_comb begin
      for (int b = 0; b < 8; b++) begin
         lo_w[b] = o_prio_levels[4 + 2 * b];
         hi_w[b] = o_prio_levels[5 + 2 * b];
      end
   end
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   // ----------------------------------------------------------------
   // register access
   // ----------------------------------------------------------------
   a_ack_mapped_read: assert property (i_sfr_rd && mapped_w |=> o_sfr_ack)
      else $error("no ack after mapped read");
   a_unmapped_read_zero: assert property (i_sfr_rd && !mapped_w |=> !o_sfr_ack && o_sfr_rdata == 8'h00)
      else $error("unmapped read answered");
   a_rdata_hold: assert property (!i_sfr_rd |=> $stable(o_sfr_rdata))
      else $error("read data moved without read");
   a_prio_low_write: assert property (i_sfr_wr && i_sfr_addr == 8'hAE |=> lo_w == $past(i_sfr_wdata))
      else $error("low priority bits wrong after write");
   a_prio_high_write: assert property (i_sfr_wr && i_sfr_addr == 8'hAF |=> hi_w == $past(i_sfr_wdata))
      else $error("high priority bits wrong after write");
   // ----------------------------------------------------------------
   // request gating and polarity
   // ----------------------------------------------------------------
   a_cmp1_gate_cause: assert property (o_cmp1_irq_req |-> $past(i_cmp1_irq_req))
      else $error("comparator 1 request without cause");
   a_t3_gate_cause: assert property (o_timer3_irq_req |-> $past(i_timer3_irq_req))
      else $error("timer 3 request without cause");
   a_cmp1_enable_pass: assert property ((i_sfr_wr && i_sfr_addr == 8'hA5 && i_sfr_wdata[1]) ##1
      (i_cmp1_irq_req && !i_sfr_wr) |=> o_cmp1_irq_req)
      else $error("enabled comparator 1 request blocked");
   a_active_polarity: assert property (o_xirq_active == (o_xirq_filtered ^ ~i_xirq_high_polarity))
      else $error("active level does not follow polarity");
   c_read_ack: cover property (o_sfr_ack);
   c_cmp1_req: cover property (o_cmp1_irq_req);
   c_filter_fall: cover property ($fell(o_xirq_filtered[0]));
endmodule : xic_asserts

bind xic_top xic_asserts chk_u (.i_sys_clk, .i_sys_rst, .i_sfr_addr, .i_sfr_page, .i_sfr_wr,
   .i_sfr_rd, .i_sfr_wdata, .o_sfr_rdata, .o_sfr_ack, .i_cmp1_irq_req, .i_timer3_irq_req,
   .o_cmp1_irq_req, .o_timer3_irq_req, .o_prio_levels, .i_xirq_high_polarity,
   .o_xirq_filtered, .o_xirq_active);

// File: testbench.sv
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
   $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_sys_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [7:0] i_sfr_addr = 8'h00;
   logic [3:0] i_sfr_page = 4'h0;
   logic i_sfr_wr = 1'b0;
   logic i_sfr_rd = 1'b0;
   logic [7:0] i_sfr_wdata = 8'h00;
   logic [47:0] pins = '1;
   logic [3:0] i_xirq_high_polarity = 4'h0;
   logic i_timer3_overflow_tick = 1'b0;
   logic i_cmp1_irq_req = 1'b0;
   logic i_timer3_irq_req = 1'b0;
   logic [7:0] o_sfr_rdata;
   logic o_sfr_ack;
   logic o_cmp1_irq_req;
   logic o_timer3_irq_req;
   xic_pkg::xic_prio_t o_prio_levels;
   logic [3:0] o_xirq_filtered;
   logic [3:0] o_xirq_active;
   logic [3:0] e;
   int n_errors = 0;
   int checks = 0;
   // port.bit codes per input and select code
   logic [7:0] tab [4][8] = '{'{8'h32, 8'h30, 8'h34, 8'h40, 8'h10, 8'h14, 8'h36, 8'h05},
      '{8'h33, 8'h31, 8'h35, 8'h41, 8'h45, 8'h15, 8'h37, 8'h07},
      '{8'h43, 8'h20, 8'h11, 8'h26, 8'h44, 8'h60, 8'h01, 8'h46},
      '{8'h42, 8'h21, 8'h00, 8'h16, 8'h02, 8'h61, 8'h06, 8'h47}};
   xic_top dut_u (.i_sys_clk, .i_sys_rst, .i_sfr_addr, .i_sfr_page, .i_sfr_wr, .i_sfr_rd,
      .i_sfr_wdata, .o_sfr_rdata, .o_sfr_ack, .i_port_pins(xic_pkg::xic_pins_t'(pins)),
      .i_xirq_high_polarity, .i_timer3_overflow_tick, .i_cmp1_irq_req, .i_timer3_irq_req,
      .o_cmp1_irq_req, .o_timer3_irq_req, .o_prio_levels, .o_xirq_filtered, .o_xirq_active);
   always #4 i_sys_clk = ~i_sys_clk;
   function automatic int pidx(input logic [7:0] b);
      return ((b[7:4] == 4'h6) ? 40 : int'(b[7:4]) * 8) + int'(b[2:0]);
   endfunction : pidx
   task automatic cyc(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [3:0] p, input logic [7:0] d);
      cyc(1);
      i_sfr_addr = a;
      i_sfr_page = p;
      i_sfr_wdata = d;
      i_sfr_wr = 1'b1;
      cyc(1);
      i_sfr_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [3:0] p, input logic [7:0] x, input logic k);
      cyc(1);
      i_sfr_addr = a;
      i_sfr_page = p;
      i_sfr_rd = 1'b1;
      cyc(1);
      i_sfr_rd = 1'b0;
      `CHK(o_sfr_rdata, x)
      `CHK(o_sfr_ack, k)
   endtask : rd
   task automatic hold_pin(input logic v, input int n, input logic tk);
      for (int i = 0; i < n; i++) begin
         pins[26] = v;
         // last step of every hold used leaves the tick low, so no second write is needed
         i_timer3_overflow_tick = tk && (i % 3 == 1);
         cyc(1);
      end
   endtask : hold_pin
   // glitch must be rejected, a long hold must pass
   task automatic filt(input logic [1:0] m, input int g, input int h, input logic tk);
      wr(8'hC1, 4'h0, {7'h00, m[0]});
      wr(8'hC1, 4'h1, {7'h00, m[1]});
      hold_pin(1'b1, 40, tk);
      hold_pin(1'b0, g, tk);
      hold_pin(1'b1, 12, tk);
      `CHK(o_xirq_filtered[0], 1'b1)
      hold_pin(1'b0, h, tk);
      cyc(2);
      `CHK(o_xirq_filtered[0], 1'b0)
   endtask : filt
   task automatic complete_run;
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : complete_run
   initial begin
      #200000;
      n_errors++;
      complete_run();
   end
   initial begin
      repeat (12) @(posedge i_sys_clk);
      #1;
      i_sys_rst = 1'b0;
      // ----------------------------------------------------------------
      // reset values, write and read back, unmapped places
      // ----------------------------------------------------------------
      for (int i = 0; i < 8; i++) rd(8'hA5 + 8'(i), 4'h0, 8'h00, i < 3 || i > 8);
      rd(8'hC1, 4'h1, 8'h00, 1'b1);
      wr(8'hAE, 4'h3, 8'hA5);
      wr(8'hAF, 4'hF, 8'h5A);
      wr(8'hA6, 4'h0, 8'h02);
      wr(8'hA7, 4'h0, 8'h01);
      rd(8'hAE, 4'h0, 8'hA5, 1'b1);
      rd(8'hAF, 4'h0, 8'h5A, 1'b1);
      // low byte 0xA5 and high byte 0x5A: low bit b is b[0] xnor b[2], high bit its inverse
      for (int b = 0; b < 8; b++) `CHK(o_prio_levels[4 + 2 * b +: 2], {b[0] ^ b[2], b[0] ~^ b[2]})
      `CHK(o_prio_levels[3:0], 4'h6)
      rd(8'hB0, 4'h0, 8'h00, 1'b0);
      // ----------------------------------------------------------------
      // request gating
      // ----------------------------------------------------------------
      i_cmp1_irq_req = 1'b1;
      i_timer3_irq_req = 1'b1;
      wr(8'hA5, 4'h0, 8'h02);
      cyc(2);
      `CHK({o_cmp1_irq_req, o_timer3_irq_req}, 2'b10)
      wr(8'hA5, 4'h0, 8'h01);
      cyc(2);
      `CHK({o_cmp1_irq_req, o_timer3_irq_req}, 2'b01)
      rd(8'hA5, 4'h0, 8'h01, 1'b1);
      // ----------------------------------------------------------------
      // pin selection for every code, bypass filter
      // ----------------------------------------------------------------
      i_xirq_high_polarity = 4'h5;
      for (int c = 0; c < 8; c++) begin
         wr(8'hC1, 4'h0, {c[1:0], c[1:0], 4'h0});
         wr(8'hC1, 4'h1, {c[2], c[2], c[1:0], 4'h0});
         wr(8'hC1, 4'h2, {4'h0, c[2:0], c[2]});
         for (int n = 0; n < 4; n++) begin
            pins = '1;
            pins[pidx(tab[n][c])] = 1'b0;
            cyc(5);
            for (int m = 0; m < 4; m++) e[m] = pins[pidx(tab[m][c])];
            `CHK(o_xirq_filtered, e)
            `CHK(o_xirq_active, e ^ ~i_xirq_high_polarity)
         end
      end
      wr(8'hC1, 4'h3, 8'h00);
      rd(8'hC1, 4'h0, 8'hF0, 1'b1);
      rd(8'hC1, 4'h1, 8'hF0, 1'b1);
      rd(8'hC1, 4'h2, 8'h0F, 1'b1);
      rd(8'hC1, 4'h3, 8'h00, 1'b0);
      // ----------------------------------------------------------------
      // filter modes on input 0
      // ----------------------------------------------------------------
      pins = '1;
      wr(8'hC1, 4'h2, 8'h00);
      filt(xic_pkg::XIC_FILT_SYSTEM_CLOCK, 2, 8, 1'b0);
      filt(xic_pkg::XIC_FILT_DIV6, 8, 30, 1'b0);
      filt(xic_pkg::XIC_FILT_T3, 6, 12, 1'b1);
      complete_run();
   end
endmodule : testbench
